// >>> rtl/async_serial_pkg.sv
package async_serial_pkg;
	// Register indices on the plain register port.
	localparam logic [2:0] ADDR_MAIN_CTRL = 3'h0;
	localparam logic [2:0] ADDR_FRAME_FMT = 3'h1;
	localparam logic [2:0] ADDR_BAUD_DIV = 3'h2;
	localparam logic [2:0] ADDR_TX_DATA = 3'h3;
	localparam logic [2:0] ADDR_RX_DATA = 3'h4;
	localparam logic [2:0] ADDR_ERR_STATUS = 3'h5;
	localparam logic [2:0] ADDR_IRQ_STATUS = 3'h6;
	localparam logic [2:0] ADDR_IRQ_ENABLE = 3'h7;
	// Main control bit positions.
	localparam int POS_POWER = 7;
	localparam int POS_TXEN = 6;
	localparam int POS_RXEN = 5;
	// Frame format bit positions.
	localparam int POS_PAR_EN = 0;
	localparam int POS_PAR_ODD = 1;
	localparam int POS_TWO_STOP = 2;
	// Error status bit positions.
	localparam int POS_ERR_PARITY = 0;
	localparam int POS_ERR_FRAME = 1;
	localparam int POS_ERR_OVERRUN = 2;
	// Interrupt status bit positions: receive complete, transmit done.
	localparam int POS_IRQ_RX = 0;
	localparam int POS_IRQ_TX = 1;
	// Reset values.
	localparam logic [7:0] RST_MAIN_CTRL = 8'h00;
	localparam logic [7:0] RST_FRAME_FMT = 8'h00;
	localparam logic [7:0] RST_BAUD_DIV = 8'h0f;
	// Extra base clocks between frames in back-to-back transmission.
	localparam logic [3:0] BACK_TO_BACK_GAP = 4'h2;
	// Oversampling per bit.
	localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;
	localparam logic [3:0] OVERSAMPLE_MID = 4'h7;
	typedef enum logic [3:0] {
		SER_IDLE = 4'b0001,
		SER_START = 4'b0010,
		SER_DATA = 4'b0100,
		SER_STOP = 4'b1000
	} ser_state_t;
endpackage : async_serial_pkg

// >>> rtl/baud_tick.sv
`timescale 1ns/100ps
// Divides the base clock into oversample ticks; restart realigns the phase.
module baud_tick (
	input wire logic clock,
	input wire logic rst,
	input wire logic run,
	input wire logic restart,
	input wire logic [7:0] divisor,
	output logic tick
);
	logic [7:0] count_ff;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			count_ff <= 8'h00;
		end else if (!run || restart || count_ff == divisor) begin
			count_ff <= 8'h00;
		end else begin
			count_ff <= count_ff + 8'h01;
		end
	end

	assign tick = run && !restart && count_ff == divisor;
endmodule : baud_tick

// >>> rtl/async_serial_port.sv
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
// What this block does
// - Stopped clock freezes operation; all registers keep their values.
// - Transmit pin holds its last level while the clock is stopped.
// - No error interrupt; errors only recorded in error status.
// - Each transmit data write with power and transmit enable is sent, unless a later write replaces its byte or an enable drops before its frame ends.
// - Back-to-back frames get two extra base clocks of gap.
// - Receiver realigns sampling on every detected start bit.
module async_serial_port (
	input wire logic clock,
	input wire logic rst,
	input wire logic [2:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdData,
	input wire logic serialRxPin,
	output logic serialTxPin,
	output logic irq
);
	logic [7:0] mainCtrl_ff;
	logic [7:0] frameFmt_ff;
	logic [7:0] baudDiv_ff;
	logic [7:0] rxData_ff;
	logic [2:0] errStatus_ff;
	logic [1:0] irqStatus_ff;
	logic [1:0] irqEnable_ff;
	logic [7:0] regRdData_ff;
	logic power;
	logic txRun;
	logic rxRun;
	logic txStart;
	logic txTick;
	logic rxTick;
	logic rxRestart;
	logic txDoneEvt;
	logic rxDoneEvt;
	logic parityErr;
	logic frameErr;
	logic overrunErr;
	logic rxSync0_ff;
	logic rxSync1_ff;
	logic rxPrev_ff;
	logic rxUnread_ff;

	// flops keep state
	// A stopped clock simply stops every flop below, so all state is kept.
	// power gates engines
	assign power = mainCtrl_ff[async_serial_pkg::POS_POWER];
	assign txRun = power && mainCtrl_ff[async_serial_pkg::POS_TXEN];
	assign rxRun = power && mainCtrl_ff[async_serial_pkg::POS_RXEN];
	assign txStart = regWrite && regAddr == async_serial_pkg::ADDR_TX_DATA && txRun;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mainCtrl_ff <= async_serial_pkg::RST_MAIN_CTRL;
			frameFmt_ff <= async_serial_pkg::RST_FRAME_FMT;
			baudDiv_ff <= async_serial_pkg::RST_BAUD_DIV;
			irqEnable_ff <= 2'h0;
		end else if (regWrite) begin
			case (regAddr)
				async_serial_pkg::ADDR_MAIN_CTRL: mainCtrl_ff <= regWrData & 8'he0;
				async_serial_pkg::ADDR_FRAME_FMT: frameFmt_ff <= regWrData & 8'h07;
				async_serial_pkg::ADDR_BAUD_DIV: baudDiv_ff <= regWrData;
				async_serial_pkg::ADDR_IRQ_ENABLE: irqEnable_ff <= regWrData[1:0];
				default: ;
			endcase
		end
	end

	// Receive input crosses in through two flops before anything reads it.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rxSync0_ff <= 1'b1;
			rxSync1_ff <= 1'b1;
			rxPrev_ff <= 1'b1;
		end else begin
			rxSync0_ff <= serialRxPin;
			rxSync1_ff <= rxSync0_ff;
			rxPrev_ff <= rxSync1_ff;
		end
	end

	// ---- Transmitter ----
	async_serial_pkg::ser_state_t txState_ff;
	logic [7:0] txShift_ff;
	logic [3:0] txSub_ff;
	logic [2:0] txBit_ff;
	logic txParity_ff;
	logic txParPhase_ff;
	logic txStop2_ff;
	logic [3:0] txGap_ff;
	logic txPending_ff;
	logic [7:0] txHold_ff;

	baud_tick txBaud (
		.clock(clock),
		.rst(rst),
		.run(txRun),
		.restart(1'b0),
		.divisor(baudDiv_ff),
		.tick(txTick)
	);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			txPending_ff <= 1'b0;
			txHold_ff <= 8'h00;
		end else if (!txRun) begin
			txPending_ff <= 1'b0;
		end else if (txStart) begin
			txPending_ff <= 1'b1;
			txHold_ff <= regWrData;
		end else if (txState_ff == async_serial_pkg::SER_IDLE && txGap_ff <= 4'h1) begin
			txPending_ff <= 1'b0;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			txState_ff <= async_serial_pkg::SER_IDLE;
			txShift_ff <= 8'h00;
			txSub_ff <= 4'h0;
			txBit_ff <= 3'h0;
			txParity_ff <= 1'b0;
			txParPhase_ff <= 1'b0;
			txStop2_ff <= 1'b0;
			txGap_ff <= 4'h0;
			serialTxPin <= 1'b1;
		end else if (!txRun) begin
			txState_ff <= async_serial_pkg::SER_IDLE;
			txGap_ff <= 4'h0;
			serialTxPin <= 1'b1;
		end else begin
			case (txState_ff)
				async_serial_pkg::SER_IDLE: begin
					// extra back-to-back gap
					// Idle itself costs one clock, so the start is released at a count of one.
					if (txGap_ff != 4'h0) begin
						txGap_ff <= txGap_ff - 4'h1;
					end
					if (txGap_ff <= 4'h1 && txPending_ff) begin
						txState_ff <= async_serial_pkg::SER_START;
						txShift_ff <= txHold_ff;
						txParity_ff <= frameFmt_ff[async_serial_pkg::POS_PAR_ODD];
						txSub_ff <= 4'h0;
						txBit_ff <= 3'h0;
						txParPhase_ff <= 1'b0;
						txStop2_ff <= 1'b0;
						serialTxPin <= 1'b0;
					end
				end
				async_serial_pkg::SER_START: if (txTick) begin
					txSub_ff <= txSub_ff + 4'h1;
					if (txSub_ff == async_serial_pkg::OVERSAMPLE_LAST) begin
						txState_ff <= async_serial_pkg::SER_DATA;
						serialTxPin <= txShift_ff[0];
					end
				end
				async_serial_pkg::SER_DATA: if (txTick) begin
					txSub_ff <= txSub_ff + 4'h1;
					if (txSub_ff == async_serial_pkg::OVERSAMPLE_LAST) begin
						if (txParPhase_ff || (txBit_ff == 3'h7 &&
								!frameFmt_ff[async_serial_pkg::POS_PAR_EN])) begin
							txState_ff <= async_serial_pkg::SER_STOP;
							serialTxPin <= 1'b1;
						end else if (txBit_ff == 3'h7) begin
							txParPhase_ff <= 1'b1;
							serialTxPin <= txParity_ff ^ txShift_ff[0];
						end else begin
							txBit_ff <= txBit_ff + 3'h1;
							txParity_ff <= txParity_ff ^ txShift_ff[0];
							txShift_ff <= {1'b0, txShift_ff[7:1]};
							serialTxPin <= txShift_ff[1];
						end
					end
				end
				async_serial_pkg::SER_STOP: if (txTick) begin
					txSub_ff <= txSub_ff + 4'h1;
					if (txSub_ff == async_serial_pkg::OVERSAMPLE_LAST) begin
						if (frameFmt_ff[async_serial_pkg::POS_TWO_STOP] && !txStop2_ff) begin
							txStop2_ff <= 1'b1;
						end else begin
							txState_ff <= async_serial_pkg::SER_IDLE;
							txGap_ff <= async_serial_pkg::BACK_TO_BACK_GAP;
						end
					end
				end
				default: txState_ff <= async_serial_pkg::SER_IDLE;
			endcase
		end
	end

	assign txDoneEvt = txRun && txTick && txState_ff == async_serial_pkg::SER_STOP &&
		txSub_ff == async_serial_pkg::OVERSAMPLE_LAST &&
		(!frameFmt_ff[async_serial_pkg::POS_TWO_STOP] || txStop2_ff);

	// ---- Receiver ----
	async_serial_pkg::ser_state_t rxState_ff;
	logic [7:0] rxShift_ff;
	logic [3:0] rxSub_ff;
	logic [2:0] rxBit_ff;
	logic rxParity_ff;
	logic rxParPhase_ff;
	logic rxParBad_ff;

	assign rxRestart = rxState_ff == async_serial_pkg::SER_IDLE && rxPrev_ff && !rxSync1_ff;

	baud_tick rxBaud (
		.clock(clock),
		.rst(rst),
		.run(rxRun),
		.restart(rxRestart),
		.divisor(baudDiv_ff),
		.tick(rxTick)
	);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rxState_ff <= async_serial_pkg::SER_IDLE;
			rxShift_ff <= 8'h00;
			rxSub_ff <= 4'h0;
			rxBit_ff <= 3'h0;
			rxParity_ff <= 1'b0;
			rxParPhase_ff <= 1'b0;
			rxParBad_ff <= 1'b0;
		end else if (!rxRun) begin
			rxState_ff <= async_serial_pkg::SER_IDLE;
		end else begin
			case (rxState_ff)
				async_serial_pkg::SER_IDLE: if (rxRestart) begin
					rxState_ff <= async_serial_pkg::SER_START;
					rxSub_ff <= 4'h0;
					rxBit_ff <= 3'h0;
					rxParPhase_ff <= 1'b0;
					rxParBad_ff <= 1'b0;
					rxParity_ff <= frameFmt_ff[async_serial_pkg::POS_PAR_ODD];
				end
				async_serial_pkg::SER_START: if (rxTick) begin
					rxSub_ff <= rxSub_ff + 4'h1;
					// A glitch shorter than half a bit is not a start bit.
					if (rxSub_ff == async_serial_pkg::OVERSAMPLE_MID && rxSync1_ff) begin
						rxState_ff <= async_serial_pkg::SER_IDLE;
					end else if (rxSub_ff == async_serial_pkg::OVERSAMPLE_LAST) begin
						rxState_ff <= async_serial_pkg::SER_DATA;
					end
				end
				async_serial_pkg::SER_DATA: if (rxTick) begin
					rxSub_ff <= rxSub_ff + 4'h1;
					if (rxSub_ff == async_serial_pkg::OVERSAMPLE_MID) begin
						if (rxParPhase_ff) begin
							rxParBad_ff <= rxParity_ff ^ rxSync1_ff;
						end else begin
							rxShift_ff <= {rxSync1_ff, rxShift_ff[7:1]};
							rxParity_ff <= rxParity_ff ^ rxSync1_ff;
						end
					end else if (rxSub_ff == async_serial_pkg::OVERSAMPLE_LAST) begin
						if (rxParPhase_ff || (rxBit_ff == 3'h7 &&
								!frameFmt_ff[async_serial_pkg::POS_PAR_EN])) begin
							rxState_ff <= async_serial_pkg::SER_STOP;
						end else if (rxBit_ff == 3'h7) begin
							rxParPhase_ff <= 1'b1;
						end else begin
							rxBit_ff <= rxBit_ff + 3'h1;
						end
					end
				end
				// Only the first stop bit is checked, so the next start is not missed.
				async_serial_pkg::SER_STOP: if (rxTick && rxSub_ff == async_serial_pkg::OVERSAMPLE_MID) begin
					rxState_ff <= async_serial_pkg::SER_IDLE;
				end else if (rxTick) begin
					rxSub_ff <= rxSub_ff + 4'h1;
				end
				default: rxState_ff <= async_serial_pkg::SER_IDLE;
			endcase
		end
	end

	assign rxDoneEvt = rxRun && rxTick && rxState_ff == async_serial_pkg::SER_STOP &&
		rxSub_ff == async_serial_pkg::OVERSAMPLE_MID;
	assign parityErr = rxDoneEvt && rxParBad_ff;
	assign frameErr = rxDoneEvt && !rxSync1_ff;
	assign overrunErr = rxDoneEvt && rxUnread_ff;

	// An overrun keeps the older byte so software sees what it missed.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rxData_ff <= 8'h00;
			rxUnread_ff <= 1'b0;
		end else if (rxDoneEvt && !rxUnread_ff) begin
			rxData_ff <= rxShift_ff;
			rxUnread_ff <= 1'b1;
		end else if (regRead && regAddr == async_serial_pkg::ADDR_RX_DATA) begin
			rxUnread_ff <= 1'b0;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			errStatus_ff <= 3'h0;
		end else begin
			errStatus_ff <= (errStatus_ff & ~((regWrite &&
				regAddr == async_serial_pkg::ADDR_ERR_STATUS) ? regWrData[2:0] : 3'h0))
				| {overrunErr, frameErr, parityErr};
		end
	end

	// Sticky events; a set in the same cycle as a clear wins.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irqStatus_ff <= 2'h0;
		end else begin
			irqStatus_ff <= (irqStatus_ff & ~((regWrite &&
				regAddr == async_serial_pkg::ADDR_IRQ_STATUS) ? regWrData[1:0] : 2'h0))
				| {txDoneEvt, rxDoneEvt};
		end
	end

	assign irq = |(irqStatus_ff & irqEnable_ff);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			regRdData_ff <= 8'h00;
		end else if (regRead) begin
			case (regAddr)
				async_serial_pkg::ADDR_MAIN_CTRL: regRdData_ff <= mainCtrl_ff;
				async_serial_pkg::ADDR_FRAME_FMT: regRdData_ff <= frameFmt_ff;
				async_serial_pkg::ADDR_BAUD_DIV: regRdData_ff <= baudDiv_ff;
				async_serial_pkg::ADDR_RX_DATA: regRdData_ff <= rxData_ff;
				async_serial_pkg::ADDR_ERR_STATUS: regRdData_ff <= {5'h00, errStatus_ff};
				async_serial_pkg::ADDR_IRQ_STATUS: regRdData_ff <= {6'h00, irqStatus_ff};
				async_serial_pkg::ADDR_IRQ_ENABLE: regRdData_ff <= {6'h00, irqEnable_ff};
				default: regRdData_ff <= 8'h00;
			endcase
		end else begin
			regRdData_ff <= 8'h00;
		end
	end

	assign regRdData = regRdData_ff;

	tx_start_a: assert property (@(posedge clock) disable iff (rst)
		txStart && txState_ff == async_serial_pkg::SER_IDLE && txGap_ff == 4'h0 && !txPending_ff
		|=> txPending_ff ##1 txState_ff == async_serial_pkg::SER_START)
		else $error("transmit write did not start a frame");
	tx_gap_a: assert property (@(posedge clock) disable iff (rst)
		txDoneEvt |=> txGap_ff == async_serial_pkg::BACK_TO_BACK_GAP &&
		txState_ff == async_serial_pkg::SER_IDLE ##1 txState_ff == async_serial_pkg::SER_IDLE)
		else $error("back to back gap missing");
	power_off_a: assert property (@(posedge clock) disable iff (rst)
		!power |=> txState_ff == async_serial_pkg::SER_IDLE &&
		rxState_ff == async_serial_pkg::SER_IDLE && serialTxPin)
		else $error("engine active without power");
	rx_align_a: assert property (@(posedge clock) disable iff (rst)
		rxRun && rxRestart |=> rxState_ff == async_serial_pkg::SER_START &&
		rxSub_ff == 4'h0 && rxBaud.count_ff == 8'h00)
		else $error("receiver did not realign");
	err_noirq_a: assert property (@(posedge clock) disable iff (rst)
		(parityErr || frameErr) |=> errStatus_ff != 3'h0 && irqStatus_ff[1] == $past(irqStatus_ff[1] | txDoneEvt))
		else $error("error status not recorded");
	tx_hold_a: assert property (@(posedge clock) disable iff (rst)
		txState_ff == async_serial_pkg::SER_IDLE && !$rose(txState_ff[1]) |-> serialTxPin)
		else $error("transmit pin not idle high");
endmodule : async_serial_port

// >>> verif/remote_station.sv
`timescale 1ns/100ps
// Far-side serial station. It runs free of the port's clock gate, as a real peer would.
module remote_station #(
	parameter int BIT_CYCLES = 16
) (
	input wire logic clock,
	input wire logic txLine,
	output logic rxLine,
	output logic [7:0] lastByte,
	output int frameCount,
	output int lastGap
);
	int cycle = 0;
	int lastStart = 0;
	always @(posedge clock) cycle <= cycle + 1;
	// Decoder uses the exact bit period of the port.
	// Sampling on the falling edge keeps the decoder clear of the edge that moves the pin.
	initial begin
		// Line serves the serial receiver alone.
		rxLine = 1'b1;
		lastByte = 8'h00;
		frameCount = 0;
		lastGap = 0;
		forever begin
			@(negedge clock);
			if (txLine === 1'b0) begin
				lastGap = cycle - lastStart;
				lastStart = cycle;
				repeat (BIT_CYCLES / 2) @(negedge clock);
				for (int i = 0; i < 8; i++) begin
					repeat (BIT_CYCLES) @(negedge clock);
					lastByte[i] = txLine;
				end
				repeat (BIT_CYCLES) @(negedge clock);
				frameCount = frameCount + 1;
			end
		end
	end
	// Frames leave at exactly the configured bit period.
	task automatic send(input logic [7:0] data, input logic stopLevel);
		logic [9:0] frame;
		frame = {stopLevel, data, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clock);
			rxLine <= frame[i];
			repeat (BIT_CYCLES - 1) @(posedge clock);
		end
		@(posedge clock);
		rxLine <= 1'b1;
	endtask : send
endmodule : remote_station

// >>> verif/testbench.sv
`timescale 1ns/100ps
module testbench;
	localparam int BIT = 16;
	localparam logic [2:0] MAIN = async_serial_pkg::ADDR_MAIN_CTRL;
	localparam logic [2:0] FMT = async_serial_pkg::ADDR_FRAME_FMT;
	localparam logic [2:0] BAUD = async_serial_pkg::ADDR_BAUD_DIV;
	localparam logic [2:0] TXD = async_serial_pkg::ADDR_TX_DATA;
	localparam logic [2:0] RXD = async_serial_pkg::ADDR_RX_DATA;
	localparam logic [2:0] ERR = async_serial_pkg::ADDR_ERR_STATUS;
	localparam logic [2:0] IST = async_serial_pkg::ADDR_IRQ_STATUS;
	localparam logic [2:0] IEN = async_serial_pkg::ADDR_IRQ_ENABLE;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic clockRun = 1'b1;
	logic dutClock;
	logic [2:0] regAddr = 3'h0;
	logic [7:0] regWrData = 8'h00;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [7:0] regRdData;
	logic serialRxPin;
	logic serialTxPin;
	logic irq;
	logic [7:0] stationByte;
	int frameCount;
	int lastGap;
	int miscompares = 0;
	int checkCount = 0;
	int cycles = 0;
	always #20 clock = ~clock;
	// Gate changes only while the clock is low, so the gated clock never glitches.
	assign dutClock = clock & clockRun;
	async_serial_port dut (.clock(dutClock), .rst(rst), .regAddr(regAddr),
		.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
		.regRdData(regRdData), .serialRxPin(serialRxPin),
		.serialTxPin(serialTxPin), .irq(irq));
	remote_station #(.BIT_CYCLES(BIT)) station (.clock(clock), .txLine(serialTxPin),
		.rxLine(serialRxPin), .lastByte(stationByte), .frameCount(frameCount),
		.lastGap(lastGap));
	task automatic testDone;
		$display("checks %0d mismatches %0d", checkCount, miscompares);
		if (miscompares == 0 && checkCount > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : testDone
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			testDone();
		end
	end
	task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] seen);
		checkCount++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check8
	task automatic check1(input string what, input logic exp, input logic seen);
		checkCount++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %b seen %b", what, exp, seen);
		end
	endtask : check1
	task automatic writeReg(input logic [2:0] addr, input logic [7:0] data);
		@(posedge clock);
		regAddr <= addr;
		regWrData <= data;
		regWrite <= 1'b1;
		@(posedge clock);
		regWrite <= 1'b0;
	endtask : writeReg
	task automatic expectReg(input logic [2:0] addr, input logic [7:0] mask,
		input logic [7:0] exp, input string what);
		@(posedge clock);
		regAddr <= addr;
		regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
		#1;
		check8(what, exp, regRdData & mask);
	endtask : expectReg
	task automatic waitCycles(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : waitCycles
	initial begin
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		expectReg(MAIN, 8'hff, async_serial_pkg::RST_MAIN_CTRL, "main reset");
		expectReg(FMT, 8'hff, async_serial_pkg::RST_FRAME_FMT, "format reset");
		expectReg(BAUD, 8'hff, async_serial_pkg::RST_BAUD_DIV, "divisor reset");
		check1("tx idle", 1'b1, serialTxPin);
		check1("irq idle", 1'b0, irq);
		$display("reset test done");
		// The divisor is set first, while power is off.
		writeReg(BAUD, 8'h00);
		writeReg(MAIN, 8'h60);
		writeReg(TXD, 8'h00);
		repeat (40) begin
			waitCycles(1);
			check1("tx unpowered", 1'b1, serialTxPin);
		end
		check1("no frame", 1'b1, frameCount == 0);
		$display("power gate test done");
		writeReg(MAIN, 8'h80);
		writeReg(MAIN, 8'he0);
		writeReg(TXD, 8'h55);
		waitCycles(20);
		writeReg(TXD, 8'h55);
		waitCycles(2 * 10 * BIT + 40);
		check1("two frames", 1'b1, frameCount == 2);
		check8("tx byte", 8'h55, stationByte);
		check1("frame gap", 1'b1, lastGap == 10 * BIT + 2);
		expectReg(IST, 8'h02, 8'h02, "tx done flag");
		$display("transmit test done");
		writeReg(IST, 8'h03);
		station.send(8'ha3, 1'b1);
		waitCycles(10);
		check1("irq masked", 1'b0, irq);
		expectReg(IST, 8'h01, 8'h01, "rx flag");
		writeReg(IEN, 8'h01);
		waitCycles(1);
		check1("irq enabled", 1'b1, irq);
		writeReg(IST, 8'h01);
		waitCycles(1);
		check1("irq cleared", 1'b0, irq);
		expectReg(RXD, 8'hff, 8'ha3, "rx byte");
		expectReg(ERR, 8'hff, 8'h00, "no error");
		writeReg(RXD, 8'h00);
		expectReg(RXD, 8'hff, 8'ha3, "rx read only");
		waitCycles(37);
		station.send(8'h5c, 1'b1);
		waitCycles(10);
		expectReg(RXD, 8'hff, 8'h5c, "rx after gap");
		$display("receive test done");
		writeReg(IST, 8'h03);
		station.send(8'h0f, 1'b0);
		waitCycles(12 * BIT);
		expectReg(ERR, 8'h02, 8'h02, "framing error");
		expectReg(IST, 8'hff, 8'h01, "no error irq");
		writeReg(ERR, 8'h07);
		expectReg(ERR, 8'h07, 8'h00, "error cleared");
		$display("error test done");
		writeReg(MAIN, 8'h80);
		writeReg(MAIN, 8'h00);
		writeReg(FMT, 8'h01);
		writeReg(MAIN, 8'h80);
		writeReg(MAIN, 8'he0);
		// The unread framed byte makes this frame an overrun as well.
		station.send(8'h01, 1'b0);
		waitCycles(2 * BIT);
		expectReg(ERR, 8'h07, 8'h05, "parity and overrun");
		expectReg(RXD, 8'hff, 8'h0f, "overrun keeps old");
		$display("parity test done");
		writeReg(TXD, 8'h00);
		waitCycles(3 * BIT);
		check1("tx low", 1'b0, serialTxPin);
		@(negedge clock);
		clockRun = 1'b0;
		repeat (40) begin
			waitCycles(1);
			check1("tx held", 1'b0, serialTxPin);
		end
		@(negedge clock);
		clockRun = 1'b1;
		expectReg(IEN, 8'hff, 8'h01, "enable kept");
		expectReg(BAUD, 8'hff, 8'h00, "divisor kept");
		expectReg(MAIN, 8'hff, 8'he0, "control kept");
		writeReg(MAIN, 8'h00);
		waitCycles(2);
		check1("tx idle again", 1'b1, serialTxPin);
		$display("clock stop test done");
		testDone();
	end
endmodule : testbench
